/* File: hdl/cdccfg_pkg.sv */
// Constants for the capacitance converter configuration register bank.
// Assumes one clock domain; shared by the bank, its word cells, the checker and the bench.
package cdccfg_pkg;

	// Word geometry
	localparam int CDCCFG_WORD_W = 24;
	localparam int CDCCFG_NUM_WORDS = 21;
	localparam int CDCCFG_ADDR_W = 5;

	// Register offsets (word addresses on the host write port)
	localparam logic [4:0] BOOT_AND_MEMORY_OPTIONS = 5'h00;
	localparam logic [4:0] OSCILLATOR_TUNING = 5'h01;
	localparam logic [4:0] CAP_PORT_AND_SCHEME = 5'h02;
	localparam logic [4:0] CAP_SEQUENCE_AND_AVERAGING = 5'h03;
	localparam logic [4:0] CAP_TEMP_TRIGGER_TIMING = 5'h04;
	localparam logic [4:0] TEMP_AVERAGING_PREDIV = 5'h05;
	localparam logic [4:0] TEMP_FAKE_AND_WIDTH = 5'h06;
	localparam logic [4:0] FIXED_DEFAULT_WORD_B = 5'h07;
	localparam logic [4:0] PROCESSOR_CONFIGURATION = 5'h08;
	localparam logic [4:0] PORT_AND_PULSE_SETTINGS = 5'h09;
	localparam logic [4:0] CORE_REGULATOR_CONTROL = 5'h0A;
	localparam logic [4:0] FIRMWARE_PARAM_UNUSED_A = 5'h0B;
	localparam logic [4:0] FIRMWARE_PARAM_UNUSED_B = 5'h0C;
	localparam logic [4:0] PULSE_SOURCE_SELECT = 5'h0D;
	localparam logic [4:0] PULSE_A_SLOPE = 5'h0E;
	localparam logic [4:0] PULSE_A_OFFSET = 5'h0F;
	localparam logic [4:0] PULSE_B_SLOPE = 5'h10;
	localparam logic [4:0] PULSE_B_OFFSET = 5'h11;
	localparam logic [4:0] DIFFERENTIAL_SETTING = 5'h12;
	localparam logic [4:0] GAIN_CORRECTION = 5'h13;
	localparam logic [4:0] RUN_CONTROL = 5'h14;

	// Reset values
	localparam logic [23:0] RST_WORD = 24'h000000;
	localparam logic [23:0] RST_OSCILLATOR_TUNING = 24'h201022;

	// Host write mask of word 0: low byte only comes from the memory copy
	localparam logic [23:0] BOOT_HOST_MASK = 24'hFFFF00;
	localparam logic [23:0] FULL_MASK = 24'hFFFFFF;

	// Field positions, word 0
	localparam int MCL_LSB = 18;
	localparam int ECC_LSB = 8;
	localparam int SBD_LSB = 4;
	localparam int RLD_LSB = 0;
	// Field positions, word 1
	localparam int OTC_LSB = 0;
	// Field positions, word 2
	localparam int SCS_LSB = 0;
	localparam int MSE_BIT = 2;
	localparam int ECD_BIT = 3;
	localparam int ICD_BIT = 4;
	localparam int STC_LSB = 6;
	localparam int DRS_LSB = 12;
	localparam int CPF_BIT = 16;
	// Field position, word 20
	localparam int RUN_BIT = 0;

	// Field codes
	localparam logic [7:0] ECC_SINGLE = 8'h00;
	localparam logic [7:0] ECC_DOUBLE = 8'h0F;
	localparam logic [7:0] ECC_QUAD = 8'hF0;
	localparam logic [11:0] ECC_LIMIT_WIDE = 12'hFC0;
	localparam logic [11:0] ECC_LIMIT_QUAD = 12'h7C0;
	localparam logic [3:0] NIBBLE_SET = 4'hF;

	typedef enum logic [1:0] {
		CDCCFG_ECC_SINGLE_T = 2'h0,
		CDCCFG_ECC_DOUBLE_T = 2'h1,
		CDCCFG_ECC_QUAD_T = 2'h3
	} cdccfg_ecc_t;

	typedef enum logic [1:0] {
		CDCCFG_SCH_GROUNDED = 2'h0,
		CDCCFG_SCH_FLOAT_SINGLE = 2'h1,
		CDCCFG_SCH_FLOAT_DIFF = 2'h2,
		CDCCFG_SCH_RESERVED = 2'h3
	} cdccfg_scheme_t;

endpackage

/* File: hdl/cdccfg_wr_if.sv */
// Write carrier between the bank and its word cells.
// Assumes the bank drives all fields from its own clock domain.
`timescale 1ns/1ns
`default_nettype none
interface cdccfg_wr_if;
	logic [20:0] sel;
	logic [23:0] data;
	logic [23:0] mask;
	modport src (output sel, output data, output mask);
	modport sink (input sel, input data, input mask);
endinterface
`default_nettype wire

/* File: hdl/cdccfg_map.sv */
// Small lookup: matches a code against a table and returns a value.
// Assumes a constant table; a code not in the table gives zero and no hit.
`timescale 1ns/1ns
`default_nettype none
module cdccfg_map #(
	parameter int N = 4,
	parameter int CW = 8,
	parameter int VW = 8,
	parameter logic [N*CW-1:0] CODES = '0,
	parameter logic [N*VW-1:0] VALUES = '0
) (
	// Code in
	input wire logic [CW-1:0] code,
	// Value out
	output logic [VW-1:0] value,
	output logic hit
);
	always_comb
	begin
		value = '0;
		hit = 1'b0;
		for (int i = 0; i < N; i++)
		begin
			if (code == CODES[i*CW +: CW])
			begin
				value = VALUES[i*VW +: VW];
				hit = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: hdl/cdccfg_word.sv */
// One 24-bit configuration word with a per-bit write mask and memory load.
// Assumes sel is one-hot and mask already reflects who is writing.
`timescale 1ns/1ns
`default_nettype none
module cdccfg_word
	import cdccfg_pkg::*;
#(
	parameter int INDEX = 0,
	parameter logic [23:0] RESET_VAL = 24'h000000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Write carrier
	cdccfg_wr_if.sink wr,
	// Stored word
	output logic [23:0] word
);
	wire logic [23:0] next_word;

	// Unmasked bits hold their value, so a write cannot touch them
	assign next_word = (wr.data & wr.mask) | (word & ~wr.mask);

	always_ff @(posedge clk or posedge reset)
		if (reset)
			word <= RESET_VAL;
		else if (wr.sel[INDEX])
			word <= next_word; // see [R17]
endmodule
`default_nettype wire

/* File: hdl/cdccfg_bank.sv */
// Configuration and parameter register bank of a capacitance converter.
// Assumes the serial host interface logic upstream delivers decoded word
// writes on CLK, and the memory boot logic delivers the protected byte.
//
// Overview of operation
// [R1] Compare length field: 0 off, 1 five, 2 thirty-three, 3 257 bytes.
// [R2] ECC codes 00 single, 0F double (4032 bytes), F0 quad (1984).
// [R3] Boot field 0 means self boot from memory; F means interface boot.
// [R4] Lock field 0 blocks memory readout; F leaves readout open.
// [R5] Host writes never change word 0 low byte; only memory copy does.
// [R6] Tuning codes 35,22,13,04 give 10,50,100,200 kHz oscillator.
// [R7] Host should program tuning code 22 for 50 kHz by default.
// [R8] Port mask: bit 16 enables first port, next bits next ports.
// [R9] Scheme 00 grounded, 01 floating single, 10 floating differential.
// [R10] Host also sets differential parameter word for differential sensors.
// [R11] Mirror bit 1 enables symmetric charge and discharge, 0 disables.
// [R12] External compensation disable bit: 0 active, 1 off.
// [R13] Internal compensation disable bit: 0 active, 1 off.
// [R14] Discharge select 100,101,110,111 give 180,90,30,10 kOhm.
// [R15] Stray field 00 both, 01 external, 10 internal, 11 none.
// [R16] Configuration words are write-only; no readback path exists.
// [R17] Every word is 24 bits and updated whole on its write, except word 0, whose low byte host writes keep.
`timescale 1ns/1ns
`default_nettype none
module cdccfg_bank #(
	parameter int NUM_PORTS = 8
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Host word write
	input wire logic WR_STROBE,
	input wire logic [cdccfg_pkg::CDCCFG_ADDR_W-1:0] WR_ADDR,
	input wire logic [cdccfg_pkg::CDCCFG_WORD_W-1:0] WR_DATA,
	// Protected byte copy from nonvolatile memory
	input wire logic MEM_LOAD,
	input wire logic [7:0] MEM_BYTE,
	// Memory options
	output logic [8:0] COMPARE_BYTES,
	output logic COMPARE_ENABLE,
	output cdccfg_pkg::cdccfg_ecc_t ECC_MODE_SEL,
	output logic [11:0] ECC_LIMIT_BYTES,
	output logic ECC_CODE_VALID,
	output logic SELF_BOOT,
	output logic READOUT_BLOCKED,
	// Oscillator
	output logic [7:0] OSC_TUNE,
	output logic [7:0] OSC_KHZ,
	output logic OSC_CODE_KNOWN,
	// Capacitance front end
	output logic [NUM_PORTS-1:0] PORT_ENABLE,
	output cdccfg_pkg::cdccfg_scheme_t SCHEME,
	output logic DIFFERENTIAL,
	output logic MIRROR_ENABLE,
	output logic EXT_COMP_ACTIVE,
	output logic INT_COMP_ACTIVE,
	output logic [7:0] DISCHARGE_KOHM,
	output logic DISCHARGE_INTERNAL,
	// Run control and raw words
	output logic RUN,
	output logic [cdccfg_pkg::CDCCFG_NUM_WORDS*24-1:0] WORDS
);
	import cdccfg_pkg::*;

	cdccfg_wr_if wr ();

	wire logic [23:0] word [CDCCFG_NUM_WORDS];
	wire logic addr_hit;
	wire logic host_boot_word;
	wire logic [20:0] host_sel;
	wire logic [23:0] host_mask;
	wire logic [23:0] mem_data;

	// Addresses above the last word are ignored without any answer
	assign addr_hit = WR_STROBE && (WR_ADDR <= RUN_CONTROL);
	assign host_boot_word = (WR_ADDR == BOOT_AND_MEMORY_OPTIONS);
	assign host_sel = addr_hit ? (21'h000001 << WR_ADDR) : 21'h000000;
	assign host_mask = host_boot_word ? BOOT_HOST_MASK : FULL_MASK; // see [R5]
	assign mem_data = {16'h0000, MEM_BYTE};

	// A memory copy and a host write to word 0 in the same cycle merge:
	// the copy owns the low byte, the host the upper two bytes.
	// The cells share one data and mask carrier, so a copy that meets a
	// host write to another word is dropped; the boot logic must retry.
	wire logic mem_ok;
	wire logic [23:0] host_wr_mask;
	wire logic [23:0] mem_mask;

	assign mem_ok = MEM_LOAD && !(addr_hit && !host_boot_word);
	assign host_wr_mask = addr_hit ? host_mask : 24'h000000;
	assign mem_mask = mem_ok ? ~BOOT_HOST_MASK : 24'h000000;
	assign wr.sel = host_sel | {20'h00000, mem_ok};
	assign wr.mask = host_wr_mask | mem_mask;
	assign wr.data = mem_ok
		? ((WR_DATA & BOOT_HOST_MASK) | mem_data) // see [R5]
		: WR_DATA;

	genvar g;
	generate
		for (g = 0; g < CDCCFG_NUM_WORDS; g++)
		begin : gen_word
			cdccfg_word #(
				.INDEX(g),
				.RESET_VAL(g == 1 ? RST_OSCILLATOR_TUNING : RST_WORD)
			) u_word (
				.clk(CLK),
				.reset(RESET),
				.wr(wr),
				.word(word[g])
			);
		end
	endgenerate

	// Field extraction
	wire logic [1:0] compare_code;
	wire logic [7:0] ecc_code;
	wire logic [3:0] boot_code;
	wire logic [3:0] lock_code;
	wire logic [7:0] tune_code;
	wire logic [1:0] scheme_code;
	wire logic [1:0] stray_code;
	wire logic [2:0] discharge_code;

	assign compare_code = word[0][MCL_LSB +: 2];
	assign ecc_code = word[0][ECC_LSB +: 8];
	assign boot_code = word[0][SBD_LSB +: 4];
	assign lock_code = word[0][RLD_LSB +: 4];
	assign tune_code = word[1][OTC_LSB +: 8];
	assign scheme_code = word[2][SCS_LSB +: 2];
	assign stray_code = word[2][STC_LSB +: 2];
	assign discharge_code = word[2][DRS_LSB +: 3];

	// Decoded values
	wire logic [8:0] compare_bytes;
	wire logic [7:0] osc_khz;
	wire logic osc_known;
	wire logic [7:0] discharge_kohm;
	wire logic discharge_internal;
	wire logic [11:0] ecc_limit;
	wire logic ecc_valid;
	cdccfg_ecc_t ecc_mode;
	wire logic self_boot;
	wire logic readout_blocked;
	wire logic stray_ext_on;
	wire logic stray_int_on;
	wire logic ext_active;
	wire logic int_active;
	wire logic [NUM_PORTS-1:0] port_enable;
	wire logic compare_enable;
	wire logic differential;
	wire logic run_flag;

	cdccfg_map #(
		.N(4),
		.CW(2),
		.VW(9),
		.CODES({2'h3, 2'h2, 2'h1, 2'h0}),
		.VALUES({9'h101, 9'h021, 9'h005, 9'h000})
	) u_compare_map (
		.code(compare_code),
		.value(compare_bytes), // see [R1]
		.hit()
	);

	cdccfg_map #(
		.N(4),
		.CW(8),
		.VW(8),
		.CODES({8'h04, 8'h13, 8'h22, 8'h35}),
		.VALUES({8'hC8, 8'h64, 8'h32, 8'h0A})
	) u_osc_map (
		.code(tune_code),
		.value(osc_khz), // see [R6]
		.hit(osc_known)
	);

	cdccfg_map #(
		.N(4),
		.CW(3),
		.VW(8),
		.CODES({3'h7, 3'h6, 3'h5, 3'h4}),
		.VALUES({8'h0A, 8'h1E, 8'h5A, 8'hB4})
	) u_discharge_map (
		.code(discharge_code),
		.value(discharge_kohm), // see [R14]
		.hit(discharge_internal)
	);

	// Unknown error-correction codes fall back to single mode
	assign ecc_valid = (ecc_code == ECC_SINGLE) || (ecc_code == ECC_DOUBLE)
		|| (ecc_code == ECC_QUAD);
	assign ecc_limit = (ecc_code == ECC_QUAD) ? ECC_LIMIT_QUAD
		: ECC_LIMIT_WIDE; // see [R2]

	always_comb
	begin
		if (ecc_code == ECC_QUAD)
			ecc_mode = CDCCFG_ECC_QUAD_T; // see [R2]
		else if (ecc_code == ECC_DOUBLE)
			ecc_mode = CDCCFG_ECC_DOUBLE_T;
		else
			ecc_mode = CDCCFG_ECC_SINGLE_T;
	end

	// Only the full code releases a protection; any other pattern keeps it
	assign self_boot = (boot_code != NIBBLE_SET); // see [R3]
	assign readout_blocked = (lock_code != NIBBLE_SET); // see [R4]

	// Bit 16 upward maps to the first port upward
	assign port_enable = word[2][CPF_BIT +: NUM_PORTS]; // see [R8]
	assign differential = (scheme_code == CDCCFG_SCH_FLOAT_DIFF); // see [R9]
	assign compare_enable = (compare_code != 2'h0); // see [R1]
	assign run_flag = word[RUN_CONTROL][RUN_BIT];

	// A compensation runs only if both its disable bit and the stray
	// field allow it; either control alone can turn it off.
	assign stray_ext_on = (stray_code == 2'h0) || (stray_code == 2'h1);
	assign stray_int_on = (stray_code == 2'h0) || (stray_code == 2'h2);
	assign ext_active = !word[2][ECD_BIT] && stray_ext_on; // see [R12] [R15]
	assign int_active = !word[2][ICD_BIT] && stray_int_on; // see [R13] [R15]

	// Output stage: every data output comes from a flip-flop
	always_ff @(posedge CLK or posedge RESET)
		if (RESET)
		begin
			COMPARE_BYTES <= 9'h000;
			COMPARE_ENABLE <= 1'b0;
			ECC_MODE_SEL <= CDCCFG_ECC_SINGLE_T;
			ECC_LIMIT_BYTES <= ECC_LIMIT_WIDE;
			ECC_CODE_VALID <= 1'b1;
			SELF_BOOT <= 1'b1;
			READOUT_BLOCKED <= 1'b1;
		end
		else
		begin
			COMPARE_BYTES <= compare_bytes;
			COMPARE_ENABLE <= compare_enable; // see [R1]
			ECC_MODE_SEL <= ecc_mode;
			ECC_LIMIT_BYTES <= ecc_limit;
			ECC_CODE_VALID <= ecc_valid;
			SELF_BOOT <= self_boot;
			READOUT_BLOCKED <= readout_blocked;
		end

	// Oscillator outputs; the reset image decodes the default tuning code
	always_ff @(posedge CLK or posedge RESET)
		if (RESET)
		begin
			OSC_TUNE <= RST_OSCILLATOR_TUNING[7:0];
			OSC_KHZ <= 8'h32;
			OSC_CODE_KNOWN <= 1'b1;
		end
		else
		begin
			OSC_TUNE <= tune_code;
			OSC_KHZ <= osc_khz;
			OSC_CODE_KNOWN <= osc_known;
		end

	// Front end outputs follow word 2 one edge after its write
	always_ff @(posedge CLK or posedge RESET)
		if (RESET)
		begin
			PORT_ENABLE <= '0;
			SCHEME <= CDCCFG_SCH_GROUNDED;
			DIFFERENTIAL <= 1'b0;
			MIRROR_ENABLE <= 1'b0;
			EXT_COMP_ACTIVE <= 1'b1;
			INT_COMP_ACTIVE <= 1'b1;
			DISCHARGE_KOHM <= 8'h00;
			DISCHARGE_INTERNAL <= 1'b0;
		end
		else
		begin
			PORT_ENABLE <= port_enable;
			SCHEME <= cdccfg_scheme_t'(scheme_code); // see [R9]
			DIFFERENTIAL <= differential;
			MIRROR_ENABLE <= word[2][MSE_BIT]; // see [R11]
			EXT_COMP_ACTIVE <= ext_active;
			INT_COMP_ACTIVE <= int_active;
			DISCHARGE_KOHM <= discharge_kohm;
			DISCHARGE_INTERNAL <= discharge_internal;
		end

	// The run flag is passed on raw; starting a run is the consumer's job
	always_ff @(posedge CLK or posedge RESET)
		if (RESET)
			RUN <= 1'b0;
		else
			RUN <= run_flag;

	// Raw words go only to the hardware and firmware consumers; there is
	// deliberately no path back to the host.
	generate
		for (g = 0; g < CDCCFG_NUM_WORDS; g++)
		begin : gen_raw
			always_ff @(posedge CLK or posedge RESET)
				if (RESET)
					WORDS[g*24 +: 24] <= (g == 1) ? RST_OSCILLATOR_TUNING
						: RST_WORD;
				else
					WORDS[g*24 +: 24] <= word[g]; // see [R16]
		end
	endgenerate
endmodule
`default_nettype wire

/* File: dv/cdccfg_bank_props.sv */
// Port checks for the configuration register bank.
// Assumes one clock domain; bound to every bank instance.
`timescale 1ns/1ns
`default_nettype none
module cdccfg_bank_props
	import cdccfg_pkg::*;
#(
	parameter int NUM_PORTS = 8
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Writes
	input wire logic WR_STROBE,
	input wire logic [4:0] WR_ADDR,
	input wire logic [23:0] WR_DATA,
	input wire logic MEM_LOAD,
	input wire logic [7:0] MEM_BYTE,
	// Decoded outputs
	input wire logic [8:0] COMPARE_BYTES,
	input wire logic COMPARE_ENABLE,
	input wire cdccfg_pkg::cdccfg_ecc_t ECC_MODE_SEL,
	input wire logic [11:0] ECC_LIMIT_BYTES,
	input wire logic SELF_BOOT,
	input wire logic READOUT_BLOCKED,
	input wire logic [7:0] OSC_TUNE,
	input wire logic [7:0] OSC_KHZ,
	input wire logic [NUM_PORTS-1:0] PORT_ENABLE,
	input wire cdccfg_pkg::cdccfg_scheme_t SCHEME,
	input wire logic DIFFERENTIAL,
	input wire logic MIRROR_ENABLE,
	input wire logic EXT_COMP_ACTIVE,
	input wire logic INT_COMP_ACTIVE,
	input wire logic [7:0] DISCHARGE_KOHM,
	input wire logic [503:0] WORDS
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	wire logic [23:0] w0 = WORDS[23:0];
	wire logic [23:0] w2 = WORDS[71:48];
	function automatic logic [7:0] khz(input logic [7:0] t);
		return t == 8'h35 ? 8'h0A : t == 8'h22 ? 8'h32 :
			t == 8'h13 ? 8'h64 : t == 8'h04 ? 8'hC8 : 8'h00;
	endfunction
	sequence host_wr;
		WR_STROBE && WR_ADDR != 5'h00 && WR_ADDR <= 5'h14;
	endsequence
	sequence stray_wr;
		WR_STROBE && WR_ADDR > 5'h14 && !MEM_LOAD;
	endsequence
	sequence mem_merge;
		MEM_LOAD && WR_STROBE && WR_ADDR == 5'h00;
	endsequence
	sequence mem_clash;
		MEM_LOAD && WR_STROBE && WR_ADDR != 5'h00 && WR_ADDR <= 5'h14;
	endsequence
	whole_word_a: assert property (host_wr |-> ##2
		WORDS[$past(WR_ADDR, 2) * 24 +: 24] == $past(WR_DATA, 2))
		else $error("host word not stored whole");
	lock_byte_a: assert property (!MEM_LOAD |-> ##2
		WORDS[7:0] == $past(WORDS[7:0]))
		else $error("protected byte changed by host");
	mem_byte_a: assert property (MEM_LOAD && !WR_STROBE |-> ##2
		WORDS[7:0] == $past(MEM_BYTE, 2))
		else $error("memory byte not loaded");
	bad_addr_a: assert property (stray_wr |-> ##2
		WORDS == $past(WORDS))
		else $error("unmapped write changed a word");
	cmp_len_a: assert property (
		COMPARE_ENABLE == (w0[19:18] != 2'h0) &&
		COMPARE_BYTES == (w0[19] ? (w0[18] ? 9'h101 : 9'h021) :
		(w0[18] ? 9'h005 : 9'h000)))
		else $error("compare length wrong");
	ecc_mode_a: assert property (w0[15:8] == 8'hF0 |->
		ECC_MODE_SEL == CDCCFG_ECC_QUAD_T && ECC_LIMIT_BYTES == 12'h7C0)
		else $error("quad correction decode wrong");
	boot_lock_a: assert property (
		SELF_BOOT == (w0[7:4] != 4'hF) && READOUT_BLOCKED == (w0[3:0] != 4'hF))
		else $error("boot or lock decode wrong");
	osc_rate_a: assert property (
		OSC_TUNE == WORDS[31:24] && OSC_KHZ == khz(OSC_TUNE))
		else $error("oscillator rate wrong");
	port_mask_a: assert property (
		PORT_ENABLE == w2[16 +: NUM_PORTS] && MIRROR_ENABLE == w2[2])
		else $error("port mask or mirror wrong");
	scheme_sel_a: assert property (
		SCHEME == w2[1:0] && DIFFERENTIAL == (w2[1:0] == 2'h2))
		else $error("scheme decode wrong");
	comp_act_a: assert property (
		EXT_COMP_ACTIVE == (!w2[3] && !w2[7]) &&
		INT_COMP_ACTIVE == (!w2[4] && !w2[6]))
		else $error("compensation decode wrong");
	discharge_a: assert property (w2[14] |-> DISCHARGE_KOHM ==
		(w2[13] ? (w2[12] ? 8'h0A : 8'h1E) : (w2[12] ? 8'h5A : 8'hB4)))
		else $error("discharge resistor wrong");
	mem_merge_a: assert property (mem_merge |-> ##2
		WORDS[23:0] == {$past(WR_DATA[23:8], 2), $past(MEM_BYTE, 2)})
		else $error("merged word 0 write wrong");
	mem_drop_a: assert property (mem_clash |-> ##2
		WORDS[23:0] == $past(WORDS[23:0]))
		else $error("clashing memory copy changed word 0");
endmodule
bind cdccfg_bank cdccfg_bank_props #(.NUM_PORTS(NUM_PORTS)) u_props (.*);
`default_nettype wire

/* File: dv/cdccfg_host_model.sv */
// Host side model: writes whole configuration words.
// Assumes callers use put and idle; lines move 10 ns after CLK.
`timescale 1ns/1ns
`default_nettype none
module cdccfg_host_model (
	// Clock
	input wire logic CLK,
	// Word write
	output logic WR_STROBE,
	output logic [4:0] WR_ADDR,
	output logic [23:0] WR_DATA
);
	initial
	begin
		WR_STROBE = 1'b0;
		WR_ADDR = 5'h1F;
		WR_DATA = 24'h000000;
	end
	// Words are only written; no readback is ever tried
	task automatic put(input logic [4:0] a, input logic [23:0] d);
		@(posedge CLK) #10;
		WR_STROBE = 1'b1;
		WR_ADDR = a;
		WR_DATA = d;
	endtask
	// Released lines invert so a stale value cannot pass
	task automatic idle();
		@(posedge CLK) #10;
		WR_STROBE = 1'b0;
		WR_ADDR = ~WR_ADDR;
		WR_DATA = ~WR_DATA;
	endtask
endmodule
`default_nettype wire

/* File: dv/cdccfg_bank_tb_top.sv */
// Self-checking bench for the configuration register bank.
// Assumes the host model and bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module cdccfg_bank_tb_top;
	import cdccfg_pkg::*;
	localparam int WD_NS = 3000 * 100;
	logic CLK = 1'b0;
	logic RESET = 1'b1;
	logic MEM_LOAD = 1'b0;
	logic [7:0] MEM_BYTE = 8'h00;
	wire logic WR_STROBE;
	wire logic [4:0] WR_ADDR;
	wire logic [23:0] WR_DATA;
	wire logic [67:0] dec;
	wire logic [503:0] wds;
	logic [23:0] sh [21];
	logic [31:0] rs = 32'h0000FF00;
	logic [7:0] tc [5] = '{8'h35, 8'h22, 8'h13, 8'h04, 8'h77};
	logic [7:0] ec [4] = '{8'h00, 8'h0F, 8'hF0, 8'h3C};
	int miscompares = 0;
	int n_checks = 0;
	always #50 CLK = ~CLK;
	cdccfg_host_model host (.CLK(CLK), .WR_STROBE(WR_STROBE),
		.WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA));
	cdccfg_bank #(.NUM_PORTS(8)) dut (.CLK(CLK), .RESET(RESET),
		.WR_STROBE(WR_STROBE), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
		.MEM_LOAD(MEM_LOAD), .MEM_BYTE(MEM_BYTE),
		.COMPARE_BYTES(dec[67:59]), .COMPARE_ENABLE(dec[58]),
		.ECC_MODE_SEL(dec[57:56]), .ECC_LIMIT_BYTES(dec[55:44]),
		.ECC_CODE_VALID(dec[43]), .SELF_BOOT(dec[42]),
		.READOUT_BLOCKED(dec[41]), .OSC_TUNE(dec[40:33]),
		.OSC_KHZ(dec[32:25]), .OSC_CODE_KNOWN(dec[24]),
		.PORT_ENABLE(dec[23:16]), .SCHEME(dec[15:14]),
		.DIFFERENTIAL(dec[13]), .MIRROR_ENABLE(dec[12]),
		.EXT_COMP_ACTIVE(dec[11]), .INT_COMP_ACTIVE(dec[10]),
		.DISCHARGE_KOHM(dec[9:2]), .DISCHARGE_INTERNAL(dec[1]),
		.RUN(dec[0]), .WORDS(wds));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [67:0] dec_exp();
		logic [23:0] a;
		logic [23:0] b;
		logic [7:0] t;
		logic [7:0] k;
		logic [7:0] r;
		a = sh[0];
		b = sh[2];
		t = sh[1][7:0];
		k = t == 8'h35 ? 8'h0A : t == 8'h22 ? 8'h32 : t == 8'h13 ? 8'h64 :
			t == 8'h04 ? 8'hC8 : 8'h00;
		r = !b[14] ? 8'h00 : b[13] ? (b[12] ? 8'h0A : 8'h1E) :
			(b[12] ? 8'h5A : 8'hB4);
		return {a[19] ? (a[18] ? 9'h101 : 9'h021) : (a[18] ? 9'h005 : 9'h000),
			a[19:18] != 2'h0, a[15:8] == 8'hF0 ? 2'h3 :
			a[15:8] == 8'h0F ? 2'h1 : 2'h0,
			a[15:8] == 8'hF0 ? 12'h7C0 : 12'hFC0,
			a[15:8] == 8'h00 || a[15:8] == 8'h0F || a[15:8] == 8'hF0,
			a[7:4] != 4'hF, a[3:0] != 4'hF, t, k, k != 8'h00, b[23:16],
			b[1:0], b[1:0] == 2'h2, b[2], !b[3] && !b[7], !b[4] && !b[6],
			r, b[14], sh[20][0]};
	endfunction
	function automatic logic [503:0] w_exp();
		logic [503:0] e;
		for (int g = 0; g < 21; g++)
			e[g * 24 +: 24] = sh[g];
		return e;
	endfunction
	task automatic chk_dec(input string n, input logic [67:0] e,
		input logic [67:0] s);
		n_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk_words(input string n, input logic [503:0] e,
		input logic [503:0] s);
		n_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// Outputs trail the taking edge by one more edge
	task automatic check_all();
		@(posedge CLK) #10;
		chk_dec("decoded outputs", dec_exp(), dec);
		chk_words("stored words", w_exp(), wds);
	endtask
	task automatic rst_sh();
		foreach (sh[g])
			sh[g] = RST_WORD;
		sh[1] = RST_OSCILLATOR_TUNING;
	endtask
	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		host.put(a, d);
		if (a == 5'h00)
			sh[0][23:8] = d[23:8];
		else if (a <= 5'h14)
			sh[a] = d;
	endtask
	task automatic mem(input logic [7:0] b);
		@(posedge CLK) #10;
		MEM_LOAD = 1'b1;
		MEM_BYTE = b;
		@(posedge CLK) #10;
		MEM_LOAD = 1'b0;
		MEM_BYTE = ~b;
		sh[0][7:0] = b;
	endtask
	task automatic complete_run();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		rst_sh();
		repeat (16) @(posedge CLK);
		#10 RESET = 1'b0;
		check_all();
		$display("test reset image done");
		foreach (tc[i])
		begin
			wr(5'h01, {16'h0000, tc[i]});
			host.idle();
			check_all();
		end
		wr(5'h01, RST_OSCILLATOR_TUNING);
		host.idle();
		check_all();
		$display("test oscillator done");
		for (int i = 0; i < 12; i++)
		begin
			rs = lfsr(rs);
			wr(5'h00, {rs[23:20], i[1:0], rs[17:16], ec[i % 4], rs[7:0]});
			host.idle();
			check_all();
		end
		for (int i = 0; i < 4; i++)
		begin
			mem(i == 3 ? 8'hFF : ec[i]);
			check_all();
		end
		$display("test memory options done");
		// Memory copy beside a host write: merged into word 0, else dropped
		for (int i = 0; i < 2; i++)
		begin
			rs = lfsr(rs);
			wr(i == 0 ? 5'h00 : 5'h05, rs[23:0]);
			MEM_LOAD = 1'b1;
			MEM_BYTE = rs[31:24];
			if (i == 0)
				sh[0][7:0] = rs[31:24];
			host.idle();
			MEM_LOAD = 1'b0;
			check_all();
		end
		$display("test memory clash done");
		for (int i = 0; i < 16; i++)
		begin
			rs = lfsr(rs);
			wr(5'h02, {rs[23:15], i[2:0], rs[11:8], i[3:2], rs[5:2], i[1:0]});
			if (i[1:0] == 2'h2)
				wr(5'h12, rs[31:8]);
			host.idle();
			check_all();
		end
		$display("test front end done");
		// Back to back, unmapped addresses among them
		for (int i = 0; i < 40; i++)
		begin
			rs = lfsr(rs);
			wr(rs[28:24], rs[23:0]);
		end
		host.idle();
		check_all();
		$display("test random writes done");
		@(posedge CLK) #10;
		RESET = 1'b1;
		rst_sh();
		repeat (3) @(posedge CLK);
		#10 RESET = 1'b0;
		check_all();
		$display("test second reset done");
		complete_run();
	end
	initial
	begin
		#WD_NS;
		miscompares++;
		$display("ERROR watchdog expected finish seen timeout");
		complete_run();
	end
endmodule
`default_nettype wire
